// [prearm_capture_sequencer.v]
// pre-arm capture sequencer: reference select, sample strobe, segment ring writes
// assumes pins arrive asynchronously and capture memory takes one address per strobe
//
// The strobed register port and the placing of the registers were chosen for this implementation.
`include "prearm_capture_consts.vh"
`timescale 1ns/1ps
`default_nettype none

module prearm_capture_sequencer #(
	parameter [15:0] SEG_SWITCH_CYCLES = `SEG_SWITCH_CYCLES
) (
	input wire i_clk_sys,
	input wire i_srst,
	input wire [7:0] i_addr,
	input wire [31:0] i_wdata,
	input wire i_wr,
	input wire i_rd,
	output reg [31:0] o_rdata,
	input wire i_clk10_ref,
	input wire i_trig_line0,
	input wire i_trig_line1,
	input wire i_front_connector_clock_input,
	input wire i_arm,
	input wire i_power_fail,
	output reg o_sample_strobe_ff,
	output reg o_mem_wr_ff,
	output reg [18:0] o_mem_addr_ff,
	output reg o_mem_prearm_ff,
	output wire o_busy,
	output wire o_irq
);

	// =====================================================================
	// states
	localparam [2:0] ST_IDLE = 3'h0;
	localparam [2:0] ST_PRE = 3'h1;
	localparam [2:0] ST_DELAY = 3'h2;
	localparam [2:0] ST_POST = 3'h3;
	localparam [2:0] ST_SWITCH = 3'h4;

	// =====================================================================
	// pin synchronisers and edge detect
	wire [5:0] pin_in;
	reg [5:0] s1_ff;
	reg [5:0] s2_ff;
	reg [5:0] s3_ff;
	reg [5:0] st_ff;
	wire [5:0] rise;

	assign pin_in = {i_power_fail, i_arm, i_front_connector_clock_input,
		i_trig_line1, i_trig_line0, i_clk10_ref};

	genvar g;
	generate
		for (g = 0; g < 6; g = g + 1) begin : g_sync
			always @(posedge i_clk_sys) begin
				if (i_srst) begin
					s1_ff[g] <= 1'b0;
					s2_ff[g] <= 1'b0;
					s3_ff[g] <= 1'b0;
					st_ff[g] <= 1'b0;
				end else begin
					s1_ff[g] <= pin_in[g];
					s2_ff[g] <= s1_ff[g];
					s3_ff[g] <= s2_ff[g];
					if (s2_ff[g] == s3_ff[g]) begin
						st_ff[g] <= s3_ff[g];
					end
				end
			end
			assign rise[g] = s2_ff[g] & s3_ff[g] & ~st_ff[g];
		end
	endgenerate

	wire arm_ev;
	wire pfail;
	assign arm_ev = rise[4];
	assign pfail = st_ff[5];

	// =====================================================================
	// internal oscillator enable
	reg [2:0] osc_div_ff;
	wire osc_tick;

	always @(posedge i_clk_sys) begin
		if (i_srst || osc_div_ff == `INTOSC_DIV - 1) begin
			osc_div_ff <= 3'h0;
		end else begin
			osc_div_ff <= osc_div_ff + 3'h1;
		end
	end
	assign osc_tick = (osc_div_ff == 3'h0) && !i_srst;

	// =====================================================================
	// configuration registers
	reg [2:0] ref_src_ff;
	reg nvm_ff;
	reg [24:0] ext_freq_ff;
	reg [15:0] interval_ff;
	reg [23:0] total_ff;
	reg [15:0] pre_mag_ff;
	reg [7:0] bursts_ff;
	reg [23:0] arm_delay_ff;
	reg [3:0] irq_mask_ff;
	reg [3:0] irq_stat_ff;
	reg [3:0] ev_ff;
	reg init_ff;
	reg abort_ff;

	wire [5:0] reg_off;
	wire in_map;
	wire [31:0] pre_neg;
	assign reg_off = i_addr[5:0];
	assign in_map = (i_addr[7] == 1'b0);
	assign pre_neg = 32'h0 - i_wdata;

	always @(posedge i_clk_sys) begin
		if (i_srst) begin
			ref_src_ff <= `SRC_INTERNAL;
			nvm_ff <= 1'b0;
			ext_freq_ff <= `EXT_FREQ_RST;
			interval_ff <= 16'h0001;
			total_ff <= 24'h000001;
			pre_mag_ff <= 16'h0000;
			bursts_ff <= 8'h01;
			arm_delay_ff <= 24'h000000;
			irq_mask_ff <= 4'h0;
			init_ff <= 1'b0;
			abort_ff <= 1'b0;
		end else begin
			init_ff <= 1'b0;
			abort_ff <= 1'b0;
			if (i_wr && in_map) begin
				case (reg_off)
					`REG_CMD: begin
						init_ff <= i_wdata[`CMD_INIT_BIT];
						abort_ff <= i_wdata[`CMD_ABORT_BIT];
					end
					`REG_CFG: begin
						ref_src_ff <= (i_wdata[2:0] > `SRC_INTERNAL) ? `SRC_INTERNAL : i_wdata[2:0]; // RULE_01 RULE_04
						nvm_ff <= i_wdata[`CFG_NVM_BIT];
					end
					`REG_EXT_FREQ: begin
						if (i_wdata < {7'h0, `EXT_FREQ_MIN}) begin
							ext_freq_ff <= `EXT_FREQ_MIN; // RULE_02
						end else if (i_wdata > {7'h0, `EXT_FREQ_MAX}) begin
							ext_freq_ff <= `EXT_FREQ_MAX; // RULE_02
						end else begin
							ext_freq_ff <= i_wdata[24:0]; // RULE_04
						end
					end
					`REG_INTERVAL: begin
						interval_ff <= (i_wdata[15:0] == 16'h0) ? 16'h0001 : i_wdata[15:0];
					end
					`REG_TOTAL: begin
						total_ff <= (i_wdata[23:0] == 24'h0) ? 24'h000001 : i_wdata[23:0]; // RULE_05
					end
					`REG_PREARM: begin
						if (!i_wdata[31] || pre_neg == 32'h1) begin
							pre_mag_ff <= 16'h0000; // RULE_11 RULE_13
						end else if (pre_neg == 32'h2) begin
							pre_mag_ff <= `PREARM_MIN; // RULE_13
						end else if (pre_neg > {16'h0, `PREARM_MAX}) begin
							pre_mag_ff <= `PREARM_MAX; // RULE_11
						end else begin
							pre_mag_ff <= pre_neg[15:0]; // RULE_11
						end
					end
					`REG_BURSTS: begin
						if (i_wdata[7:0] == 8'h0 && i_wdata[31:8] == 24'h0) begin
							bursts_ff <= 8'h01;
						end else if (i_wdata > {24'h0, `BURSTS_MAX}) begin
							bursts_ff <= `BURSTS_MAX;
						end else begin
							bursts_ff <= i_wdata[7:0];
						end
					end
					`REG_ARM_DELAY: begin
						arm_delay_ff <= i_wdata[23:0];
					end
					`REG_IRQ_MASK: begin
						irq_mask_ff <= i_wdata[3:0];
					end
					default: begin
					end
				endcase
			end
		end
	end

	// =====================================================================
	// interrupt status, set wins over write-one clear
	wire [3:0] irq_clr;
	assign irq_clr = (i_wr && in_map && reg_off == `REG_IRQ_STAT) ? i_wdata[3:0] : 4'h0;

	always @(posedge i_clk_sys) begin
		if (i_srst) begin
			irq_stat_ff <= 4'h0;
		end else begin
			irq_stat_ff <= (irq_stat_ff & ~irq_clr) | ev_ff;
		end
	end
	assign o_irq = |(irq_stat_ff & irq_mask_ff);

	// =====================================================================
	// reference tick and sample strobe generator
	reg ref_tick;
	reg [24:0] freq_w;
	reg [2:0] state_ff;
	reg [40:0] acc_ff;
	wire [40:0] thr;
	wire [40:0] acc_sum;

	always @* begin
		case (ref_src_ff)
			`SRC_CLK10: begin
				ref_tick = rise[0]; // RULE_01
				freq_w = `CLK10_HZ;
			end
			`SRC_TRIG0: begin
				ref_tick = rise[1]; // RULE_01
				freq_w = ext_freq_ff; // RULE_02
			end
			`SRC_TRIG1: begin
				ref_tick = rise[2]; // RULE_01
				freq_w = ext_freq_ff; // RULE_02
			end
			`SRC_FRONT: begin
				ref_tick = rise[3]; // RULE_01
				freq_w = ext_freq_ff; // RULE_02
			end
			default: begin
				ref_tick = osc_tick; // RULE_01
				freq_w = `INTOSC_HZ;
			end
		endcase
	end

	assign thr = {16'h0, freq_w} * {25'h0, interval_ff}; // RULE_17
	assign acc_sum = acc_ff + `US_PER_S;

	always @(posedge i_clk_sys) begin
		if (i_srst || state_ff == ST_IDLE) begin
			acc_ff <= 41'h0;
			o_sample_strobe_ff <= 1'b0;
		end else begin
			o_sample_strobe_ff <= 1'b0;
			if (ref_tick) begin // RULE_03
				if (thr <= `US_PER_S) begin
					o_sample_strobe_ff <= 1'b1; // RULE_17
					acc_ff <= 41'h0;
				end else if (acc_sum >= thr) begin
					o_sample_strobe_ff <= 1'b1; // RULE_17
					acc_ff <= acc_sum - thr;
				end else begin
					acc_ff <= acc_sum;
				end
			end
		end
	end

	// =====================================================================
	// segment geometry
	function [2:0] clog2_8;
		input [7:0] n;
		reg [3:0] i;
		begin
			clog2_8 = 3'h0;
			for (i = 4'h0; i < 4'h7; i = i + 4'h1) begin
				if (n > (8'h01 << i)) begin
					clog2_8 = i[2:0] + 3'h1;
				end
			end
		end
	endfunction

	wire [2:0] k_w;
	wire part_w;
	wire [19:0] seg_sz_w;
	wire [19:0] limit_w;
	wire cfg_ok;
	assign k_w = clog2_8(bursts_ff);
	assign part_w = (bursts_ff > 8'h01) && (pre_mag_ff >= `PREARM_MIN) &&
		(total_ff > `PART_TOTAL_MIN); // RULE_06
	assign seg_sz_w = part_w ? (`MEM_DEPTH >> k_w) : `MEM_DEPTH; // RULE_10
	assign limit_w = seg_sz_w - (nvm_ff ? `NVM_RESERVE : 20'h0); // RULE_10
	assign cfg_ok = ((pre_mag_ff == 16'h0) || (total_ff >= {8'h0, pre_mag_ff} + `POST_MIN)) &&
		({4'h0, total_ff} <= limit_w); // RULE_12

	// =====================================================================
	// capture sequencer
	reg [2:0] k_ff;
	reg part_ff;
	reg [19:0] limit_ff;
	reg [7:0] seg_ff;
	reg [7:0] burst_ff;
	reg [18:0] ptr_ff;
	reg [15:0] pre_cnt_ff;
	reg [23:0] post_left_ff;
	reg [23:0] taken_ff;
	reg [23:0] delay_ff;
	reg [15:0] sw_ff;
	wire samp_ev;
	wire [18:0] seg_base;
	wire [19:0] ptr_inc;
	wire [18:0] ptr_next;
	wire pre_met;

	assign samp_ev = o_sample_strobe_ff;
	assign seg_base = {12'h0, seg_ff[6:0]} << (5'h13 - {2'h0, k_ff});
	assign ptr_inc = {1'b0, ptr_ff} + 20'h1;
	assign ptr_next = (ptr_inc >= limit_ff) ? 19'h0 : ptr_inc[18:0]; // RULE_07
	assign pre_met = (pre_cnt_ff >= pre_mag_ff);

	always @(posedge i_clk_sys) begin
		if (i_srst) begin
			state_ff <= ST_IDLE;
			k_ff <= 3'h0;
			part_ff <= 1'b0;
			limit_ff <= `MEM_DEPTH;
			seg_ff <= 8'h0;
			burst_ff <= 8'h0;
			ptr_ff <= 19'h0;
			pre_cnt_ff <= 16'h0;
			post_left_ff <= 24'h0;
			taken_ff <= 24'h0;
			delay_ff <= 24'h0;
			sw_ff <= 16'h0;
			ev_ff <= 4'h0;
			o_mem_wr_ff <= 1'b0;
			o_mem_addr_ff <= 19'h0;
			o_mem_prearm_ff <= 1'b0;
		end else begin
			ev_ff <= 4'h0;
			o_mem_wr_ff <= 1'b0;
			if (abort_ff || pfail) begin
				state_ff <= ST_IDLE; // RULE_16
			end else begin
				case (state_ff)
					ST_IDLE: begin
						if (init_ff) begin
							if (cfg_ok) begin
								state_ff <= ST_PRE; // RULE_14
								k_ff <= part_w ? k_w : 3'h0;
								part_ff <= part_w;
								limit_ff <= limit_w;
								seg_ff <= 8'h0;
								burst_ff <= 8'h0;
								ptr_ff <= 19'h0;
								pre_cnt_ff <= 16'h0;
								taken_ff <= 24'h0;
							end else begin
								ev_ff[`IRQ_CFG_ERR] <= 1'b1; // RULE_12
							end
						end
					end
					ST_PRE: begin
						if (samp_ev && pre_mag_ff != 16'h0) begin
							o_mem_wr_ff <= 1'b1; // RULE_07
							o_mem_addr_ff <= seg_base | ptr_ff;
							o_mem_prearm_ff <= 1'b1;
							ptr_ff <= ptr_next;
							if (!pre_met) begin
								pre_cnt_ff <= pre_cnt_ff + 16'h1;
							end
							if (taken_ff != total_ff) begin
								taken_ff <= taken_ff + 24'h1; // RULE_16
							end
						end
						if (arm_ev) begin
							if (pre_met) begin
								state_ff <= ST_DELAY; // RULE_15
								delay_ff <= arm_delay_ff;
								post_left_ff <= total_ff - {8'h0, pre_mag_ff}; // RULE_15
							end else begin
								ev_ff[`IRQ_ARM_ERR] <= 1'b1; // RULE_14
							end
						end
					end
					ST_DELAY: begin
						if (delay_ff == 24'h0) begin
							state_ff <= ST_POST;
						end else if (ref_tick) begin
							delay_ff <= delay_ff - 24'h1; // RULE_03
						end
					end
					ST_POST: begin
						if (samp_ev) begin
							o_mem_wr_ff <= 1'b1; // RULE_15
							o_mem_addr_ff <= seg_base | ptr_ff;
							o_mem_prearm_ff <= 1'b0;
							ptr_ff <= ptr_next;
							post_left_ff <= post_left_ff - 24'h1;
							if (taken_ff != total_ff) begin
								taken_ff <= taken_ff + 24'h1; // RULE_16
							end
							if (post_left_ff == 24'h1) begin
								ev_ff[`IRQ_BURST] <= 1'b1;
								if (burst_ff + 8'h1 == bursts_ff) begin
									state_ff <= ST_IDLE;
									ev_ff[`IRQ_DONE] <= 1'b1;
								end else begin
									state_ff <= ST_SWITCH; // RULE_08
									sw_ff <= SEG_SWITCH_CYCLES - 16'h1;
									burst_ff <= burst_ff + 8'h1;
								end
							end
						end
					end
					ST_SWITCH: begin
						if (sw_ff == 16'h0) begin
							state_ff <= ST_PRE;
							pre_cnt_ff <= 16'h0;
							taken_ff <= 24'h0;
							if (part_ff) begin
								seg_ff <= seg_ff + 8'h1; // RULE_08
								ptr_ff <= 19'h0;
							end
						end else begin
							sw_ff <= sw_ff - 16'h1; // RULE_09
						end
					end
					default: begin
						state_ff <= ST_IDLE;
					end
				endcase
			end
		end
	end

	assign o_busy = (state_ff != ST_IDLE);

	// =====================================================================
	// register read port, one cycle latency
	always @(posedge i_clk_sys) begin
		if (i_srst) begin
			o_rdata <= 32'h0;
		end else if (i_rd && in_map) begin
			case (reg_off)
				`REG_CFG: o_rdata <= {28'h0, nvm_ff, ref_src_ff}; // RULE_04
				`REG_EXT_FREQ: o_rdata <= {7'h0, ext_freq_ff}; // RULE_04
				`REG_INTERVAL: o_rdata <= {16'h0, interval_ff};
				`REG_TOTAL: o_rdata <= {8'h0, total_ff}; // RULE_05
				`REG_PREARM: o_rdata <= 32'h0 - {16'h0, pre_mag_ff}; // RULE_11
				`REG_BURSTS: o_rdata <= {24'h0, bursts_ff};
				`REG_ARM_DELAY: o_rdata <= {8'h0, arm_delay_ff};
				`REG_STATUS: o_rdata <= {8'h0, seg_ff, burst_ff, 4'h0, pre_met, state_ff};
				`REG_TAKEN: o_rdata <= {8'h0, taken_ff}; // RULE_16
				`REG_IRQ_STAT: o_rdata <= {28'h0, irq_stat_ff};
				`REG_IRQ_MASK: o_rdata <= {28'h0, irq_mask_ff};
				default: o_rdata <= 32'h0;
			endcase
		end else begin
			o_rdata <= 32'h0;
		end
	end

endmodule // prearm_capture_sequencer

`default_nettype wire

// [prearm_capture_consts.vh]
// constants and field layout of the pre-arm capture sequencer
// assumes a 100 MHz system clock and a byte-addressed 32-bit register port
//
// What this block does
// RULE_01 - the reference clock comes from the 10 MHz backplane line, trigger line 0, trigger line 1, the front connector or the internal 20 MHz oscillator.
// RULE_02 - with the front connector or a trigger line selected, the sample rate uses the stored external frequency, held between 10 kHz and 20 MHz.
// RULE_03 - sample rate and trigger delay both count ticks of the selected reference clock.
// RULE_04 - the reference clock settings are one set, reached at the same value through either channel's address.
// RULE_05 - the reading count settings are one set, reached at the same value through either channel's address.
// RULE_06 - memory is split into a power-of-two count of segments, one per burst, when bursts exceed one, pre-arm is -3 or below and the total exceeds 9.
// RULE_07 - each segment is a ring in which pre-arm samples wrap until the arm and the post-arm samples close the burst.
// RULE_08 - after the last post-arm sample of a segment, the next burst goes to the next segment, or the same one when unsplit, until the burst count is met.
// RULE_09 - arm and sample events during the 630 us segment switch are dropped with no error.
// RULE_10 - a segment holds 524288 over the power-of-two segment count samples, four fewer in non-volatile mode.
// RULE_11 - the pre-arm count is kept as 0 or a negative value from -65535 to -3.
// RULE_12 - with a nonzero pre-arm count the total plus the negative pre-arm count must be at least 7.
// RULE_13 - a requested pre-arm count between -3 and 0 is rounded to the nearer of -3 and 0.
// RULE_14 - initiation starts pre-arm sampling, and an arm before the pre-arm count is met is dropped and flags an error.
// RULE_15 - a legal arm after the pre-arm count starts post-arm sampling for the rest of the burst total.
// RULE_16 - after an abort or power failure the count shown is the lesser of samples taken and the burst total.
// RULE_17 - the sample strobe comes from counting reference ticks against a divisor made of the reference frequency and the interval.
`ifndef PREARM_CAPTURE_CONSTS_VH
`define PREARM_CAPTURE_CONSTS_VH

// =====================================================================
// register offsets (bit 6 of the address selects the channel alias)
`define REG_CMD 6'h00
`define REG_CFG 6'h04
`define REG_EXT_FREQ 6'h08
`define REG_INTERVAL 6'h0C
`define REG_TOTAL 6'h10
`define REG_PREARM 6'h14
`define REG_BURSTS 6'h18
`define REG_ARM_DELAY 6'h1C
`define REG_STATUS 6'h20
`define REG_TAKEN 6'h24
`define REG_IRQ_STAT 6'h28
`define REG_IRQ_MASK 6'h2C

// =====================================================================
// fields and encodings
`define CMD_INIT_BIT 0
`define CMD_ABORT_BIT 1
`define CFG_NVM_BIT 3
`define SRC_CLK10 3'h0
`define SRC_TRIG0 3'h1
`define SRC_TRIG1 3'h2
`define SRC_FRONT 3'h3
`define SRC_INTERNAL 3'h4
`define IRQ_BURST 0
`define IRQ_DONE 1
`define IRQ_ARM_ERR 2
`define IRQ_CFG_ERR 3

// =====================================================================
// reset values and limits
`define EXT_FREQ_RST 25'h1312D00
`define EXT_FREQ_MIN 25'h0002710
`define EXT_FREQ_MAX 25'h1312D00
`define CLK10_HZ 25'h0989680
`define INTOSC_HZ 25'h1312D00
`define US_PER_S 41'h000000F4240
`define MEM_DEPTH 20'h80000
`define NVM_RESERVE 20'h00004
`define PREARM_MAX 16'hFFFF
`define PREARM_MIN 16'h0003
`define POST_MIN 24'h000007
`define PART_TOTAL_MIN 24'h000009
`define BURSTS_MAX 8'h80

// =====================================================================
// timing
`define SYS_CLK_HZ 100000000
`define INTOSC_FREQ_HZ 20000000
`define INTOSC_DIV (`SYS_CLK_HZ / `INTOSC_FREQ_HZ)
`define CLK_PERIOD_NS 10
`define SEG_SWITCH_US 630
`define SEG_SWITCH_CYCLES ((`SEG_SWITCH_US * 1000) / `CLK_PERIOD_NS)

`endif

// [ref_line_model.sv]
// reference line model: backplane clock, two trigger lines, front input
// assumes a 100 MHz system clock; edges stay off its rising edge
`timescale 1ns/1ps
`default_nettype none
module ref_line_model (
	output logic o_clk10,
	output logic o_trig0,
	output logic o_trig1,
	output logic o_front
);
	// =========================================================
	// free running lines: 10, 5, 2.5 and 1.25 MHz
	initial begin
		o_clk10 = 1'b0;
		o_trig0 = 1'b0;
		o_trig1 = 1'b0;
		o_front = 1'b0;
		#2;
		fork
			forever #50 o_clk10 = ~o_clk10;
			forever #100 o_trig0 = ~o_trig0;
			forever #200 o_trig1 = ~o_trig1;
			forever #400 o_front = ~o_front;
		join
	end
endmodule // ref_line_model
`default_nettype wire

// [prearm_capture_sequencer_assertions.sv]
// checker on the sequencer ports: register port, sample path, abort paths
// assumes it is bound to the sequencer and sees its ports only
`include "prearm_capture_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module prearm_capture_sequencer_assertions (
	input wire logic i_clk_sys,
	input wire logic i_srst,
	input wire logic [7:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [31:0] o_rdata,
	input wire logic i_power_fail,
	input wire logic o_sample_strobe_ff,
	input wire logic o_mem_wr_ff,
	input wire logic [18:0] o_mem_addr_ff,
	input wire logic o_busy,
	input wire logic o_irq
);
	// =========================================================
	// register port
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (i_srst);
	wire logic cmd_wr = i_wr && !i_addr[7] && i_addr[5:0] == `REG_CMD;
	wire logic mask_wr = i_wr && !i_addr[7] && i_addr[5:0] == `REG_IRQ_MASK;
	a_read_slot: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
		else $error("read data outside its slot");
	a_unmapped_read: assert property (i_rd && i_addr[7] |=> o_rdata == 32'h0)
		else $error("unmapped read not zero");
	a_count_alias: assert property (i_wr && i_addr == 8'h50 && i_wdata[31:24] == 8'h0
		&& i_wdata[23:0] != 24'h0 ##1 i_rd && i_addr == 8'h10 |=> o_rdata == $past(i_wdata, 2))
		else $error("count not shared");
	a_mask_quiet: assert property (mask_wr && i_wdata[3:0] == 4'h0 |=> !o_irq)
		else $error("irq with mask clear");
	// =========================================================
	// sample path and stopping
	a_write_follows: assert property (o_mem_wr_ff |-> $past(o_sample_strobe_ff))
		else $error("write without strobe");
	a_strobe_spacing: assert property (o_sample_strobe_ff |=> !o_sample_strobe_ff [*4])
		else $error("strobes too close");
	a_addr_hold: assert property (!o_mem_wr_ff |-> $stable(o_mem_addr_ff))
		else $error("address moved without write");
	a_abort_idle: assert property (cmd_wr && i_wdata[1] |-> ##[1:2] !o_busy)
		else $error("abort left it busy");
	a_power_idle: assert property (i_power_fail [*6] |-> !o_busy)
		else $error("busy in power fail");
endmodule // prearm_capture_sequencer_assertions
bind prearm_capture_sequencer prearm_capture_sequencer_assertions
	prearm_capture_sequencer_assertions_i (.i_clk_sys(i_clk_sys), .i_srst(i_srst),
	.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
	.i_power_fail(i_power_fail), .o_sample_strobe_ff(o_sample_strobe_ff),
	.o_mem_wr_ff(o_mem_wr_ff), .o_mem_addr_ff(o_mem_addr_ff), .o_busy(o_busy), .o_irq(o_irq));
`default_nettype wire

// [tb_prearm_capture_sequencer.sv]
// bench for the sequencer: register table, sources, bursts, errors
// assumes the reference line model drives the four reference pins
`timescale 1ns/1ps
`default_nettype none
module tb_prearm_capture_sequencer;
	typedef struct {logic [7:0] aw; logic [7:0] ar; logic [31:0] d; logic [31:0] e;} row_t;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic [7:0] addr = 8'h0;
	logic [31:0] wdata = 32'h0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic arm = 1'b0;
	logic pfail = 1'b0;
	wire logic [31:0] rdata;
	wire logic clk10, trig0, trig1, front, strobe, mem_wr, mem_pre, busy, irq;
	wire logic [18:0] mem_addr;
	logic [31:0] rdv;
	int n_mismatch = 0;
	int total_checks = 0;
	int n_wr = 0;
	int n_post = 0;
	int n_seg1 = 0;
	int k, g, i;
	int gaps[5] = '{200, 200, 400, 800, 200};
	logic [7:0] ra[9] = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h2C, 8'h20};
	logic [31:0] rv[9] = '{32'h4, 32'h1312D00, 32'h1, 32'h1, 32'h0, 32'h1, 32'h0, 32'h0, 32'h8};
	row_t rows[14] = '{'{8'h44, 8'h04, 32'h7, 32'h4}, '{8'h04, 8'h44, 32'h3, 32'h3},
		'{8'h48, 8'h08, 32'h1388, 32'h2710}, '{8'h08, 8'h48, 32'h1C9C380, 32'h1312D00},
		'{8'h48, 8'h08, 32'h4C4B40, 32'h4C4B40}, '{8'h10, 8'h50, 32'h0, 32'h1},
		'{8'h50, 8'h10, 32'h64, 32'h64}, '{8'h54, 8'h14, 32'hFFFFFFFE, 32'hFFFFFFFD},
		'{8'h14, 8'h54, 32'hFFFFFFFF, 32'h0}, '{8'h14, 8'h14, 32'h5, 32'h0},
		'{8'h14, 8'h14, 32'hFFFEEE90, 32'hFFFF0001}, '{8'h58, 8'h18, 32'h0, 32'h1},
		'{8'h18, 8'h58, 32'hC8, 32'h80}, '{8'h88, 8'h88, 32'h5, 32'h0}};

	ref_line_model ref_line_model_i (.o_clk10(clk10), .o_trig0(trig0), .o_trig1(trig1),
		.o_front(front));
	prearm_capture_sequencer #(.SEG_SWITCH_CYCLES(16'd200)) prearm_capture_sequencer_i (
		.i_clk_sys(clk), .i_srst(srst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
		.o_rdata(rdata), .i_clk10_ref(clk10), .i_trig_line0(trig0), .i_trig_line1(trig1),
		.i_front_connector_clock_input(front), .i_arm(arm), .i_power_fail(pfail),
		.o_sample_strobe_ff(strobe), .o_mem_wr_ff(mem_wr), .o_mem_addr_ff(mem_addr),
		.o_mem_prearm_ff(mem_pre), .o_busy(busy), .o_irq(irq));

	initial begin
		forever #5 clk = ~clk;
	end

	// =========================================================
	// memory write monitor
	always @(posedge clk) begin
		if (mem_wr === 1'b1) begin
			n_wr++;
			if (mem_pre === 1'b0) n_post++;
			if (mem_pre === 1'b0 && mem_addr[18] === 1'b1) n_seg1++;
		end
	end

	// =========================================================
	// tasks
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_go(input logic [7:0] a);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 rdv = rdata;
	endtask
	task automatic rd_reg(input logic [7:0] a);
		@(posedge clk);
		rd_go(a);
	endtask
	task automatic wr_rd(input logic [7:0] aw, input logic [31:0] d, input logic [7:0] ar);
		wr_reg(aw, d);
		rd_go(ar);
	endtask
	task automatic setup(input logic [31:0] c, t, p, b);
		wr_reg(8'h04, c);
		wr_reg(8'h10, t);
		wr_reg(8'h14, p);
		wr_reg(8'h18, b);
		n_wr = 0;
		n_post = 0;
		n_seg1 = 0;
	endtask
	task automatic init_cmd();
		wr_reg(8'h40, 32'h1);
		repeat (4) @(posedge clk);
	endtask
	task automatic arm_pulse();
		@(posedge clk);
		arm <= 1'b1;
		repeat (4) @(posedge clk);
		arm <= 1'b0;
	endtask
	task automatic wait_idle();
		k = 0;
		while (busy !== 1'b0 && k < 5000) begin
			@(posedge clk);
			k++;
		end
		repeat (3) @(posedge clk);
	endtask
	task automatic gap(output int n);
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (strobe !== 1'b1 && n < 3000);
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	initial begin
		#500000;
		n_mismatch++;
		conclude();
	end

	// =========================================================
	// main sequence
	initial begin
		repeat (12) @(posedge clk);
		srst <= 1'b0;
		for (i = 0; i < 9; i++) begin
			rd_reg(ra[i]);
			check(rdv, rv[i]);
		end
		for (i = 0; i < 14; i++) begin
			wr_rd(rows[i].aw, rows[i].d, rows[i].ar);
			check(rdv, rows[i].e);
		end
		// each source with abort, the last with power failure
		wr_reg(8'h0C, 32'h2);
		for (i = 0; i < 5; i++) begin
			setup(i, 32'h3E8, 32'h0, 32'h1);
			init_cmd();
			arm_pulse();
			gap(g);
			gap(g);
			check(g, gaps[i]);
			if (i < 4) wr_reg(8'h00, 32'h2);
			else pfail <= 1'b1;
			wait_idle();
			pfail <= 1'b0;
			rd_reg(8'h24);
			check(rdv, n_wr);
		end
		// early arm, interrupt mask and clear, then a legal arm
		wr_reg(8'h28, 32'hF);
		setup(32'h4, 32'h14, 32'hFFFFFFFB, 32'h1);
		init_cmd();
		arm_pulse();
		repeat (8) @(posedge clk);
		rd_reg(8'h28);
		check(rdv, 32'h4);
		check({31'h0, irq}, 32'h0);
		wr_reg(8'h2C, 32'h4);
		#1 check({31'h0, irq}, 32'h1);
		wr_reg(8'h28, 32'h4);
		#1 check({31'h0, irq}, 32'h0);
		repeat (1500) @(posedge clk);
		arm_pulse();
		wait_idle();
		check(n_post, 32'hF);
		rd_reg(8'h24);
		check(rdv, 32'h14);
		rd_reg(8'h28);
		check(rdv, 32'h3);
		wr_reg(8'h2C, 32'h0);
		wr_reg(8'h28, 32'hF);
		// two bursts in two segments, arm during the switch
		wr_reg(8'h0C, 32'h1);
		setup(32'h4, 32'hA, 32'hFFFFFFFD, 32'h2);
		init_cmd();
		repeat (500) @(posedge clk);
		arm_pulse();
		k = 0;
		while (n_post < 7 && k < 3000) begin
			@(posedge clk);
			k++;
		end
		arm_pulse();
		repeat (600) @(posedge clk);
		check(n_post, 32'h7);
		rd_reg(8'h28);
		check(rdv, 32'h1);
		arm_pulse();
		wait_idle();
		check(n_post, 32'hE);
		check(n_seg1, 32'h7);
		// refused settings, then the largest total that is accepted
		wr_reg(8'h28, 32'hF);
		setup(32'h4, 32'h8, 32'hFFFFFFFD, 32'h1);
		init_cmd();
		rd_reg(8'h28);
		check(rdv, 32'h8);
		check({31'h0, busy}, 32'h0);
		wr_reg(8'h28, 32'h8);
		setup(32'hC, 32'hFFD, 32'hFFFFFFFD, 32'h80);
		init_cmd();
		rd_reg(8'h28);
		check(rdv, 32'h8);
		wr_reg(8'h28, 32'h8);
		setup(32'hC, 32'hFFC, 32'hFFFFFFFD, 32'h80);
		init_cmd();
		check({31'h0, busy}, 32'h1);
		// reset in mid-run while busy
		srst <= 1'b1;
		repeat (3) @(posedge clk);
		srst <= 1'b0;
		#1 check({31'h0, busy}, 32'h0);
		rd_reg(8'h04);
		check(rdv, 32'h4);
		rd_reg(8'h10);
		check(rdv, 32'h1);
		conclude();
	end
endmodule // tb_prearm_capture_sequencer
`default_nettype wire
